// >>> design/cos_pkg.sv
/*
 * cos_pkg: constants, register map and carrier types shared by the
 * configurable output selector.
 * assumes a 125 MHz system clock and 32-bit Avalon-MM register access.
 */
package cos_pkg;

	localparam int unsigned CLOCK_HZ     = 125_000_000;
	// delays are held in milliseconds; one count is one millisecond
	localparam int unsigned TICK_MS      = 1;
	localparam int unsigned MS_CYCLES    = CLOCK_HZ / 1000 * TICK_MS;

	localparam int unsigned NUM_OUT      = 5;
	localparam int unsigned NUM_IN       = 8;
	localparam int unsigned DLY_W        = 20;
	localparam int unsigned SRC_W        = 4;
	localparam int unsigned OVL_W        = 16;

	// 600.0 s and 500 ms, both expressed in milliseconds
	localparam logic [DLY_W-1:0] DELAY_MAX_MS   = 20'd600000;
	localparam logic [DLY_W-1:0] HEALTHY_MIN_MS = 20'd500;
	localparam logic [DLY_W-1:0] DELAY_RESET    = 20'h00000;

	localparam logic [SRC_W-1:0] SRC_MAX        = 4'hd;
	localparam logic [SRC_W-1:0] SRC_HEALTHY    = 4'h0;
	localparam logic [SRC_W-1:0] SRC_SPEED      = 4'h1;
	localparam logic [SRC_W-1:0] SRC_ARM_LEVEL  = 4'h2;
	localparam logic [SRC_W-1:0] SRC_AT_SPEED   = 4'h3;
	localparam logic [SRC_W-1:0] SRC_AT_LIMIT   = 4'h4;
	localparam logic [SRC_W-1:0] SRC_RUNNING    = 4'h5;
	localparam logic [SRC_W-1:0] SRC_FULL_OVL   = 4'h6;
	localparam logic [SRC_W-1:0] SRC_FLD_WEAK   = 4'h7;
	localparam logic [SRC_W-1:0] SRC_FLD_LEVEL  = 4'h8;
	localparam logic [SRC_W-1:0] SRC_REF_LEVEL  = 4'h9;
	localparam logic [SRC_W-1:0] SRC_NO_WARN    = 4'ha;
	localparam logic [SRC_W-1:0] SRC_FIELDBUS   = 4'hb;
	localparam logic [SRC_W-1:0] SRC_PASS_A     = 4'hc;
	localparam logic [SRC_W-1:0] SRC_PASS_B     = 4'hd;

	localparam logic [NUM_OUT*SRC_W-1:0] SRC_RESET = {4'h4, 4'h5, 4'h2, 4'h1, 4'h0};

	// byte offsets: output n has a 16-byte block at n*0x10
	localparam logic [6:0] OFS_SRC       = 7'h00;
	localparam logic [6:0] OFS_ON        = 7'h04;
	localparam logic [6:0] OFS_OFF       = 7'h08;
	localparam logic [6:0] OFS_INV       = 7'h0c;
	localparam logic [6:0] OFS_OUT_BLOCK = 7'h10;
	localparam logic [6:0] ADR_OPTION    = 7'h50;
	localparam logic [6:0] ADR_PASS_SEL  = 7'h54;
	localparam logic [6:0] ADR_OVL_TIME  = 7'h58;
	localparam logic [6:0] ADR_STATUS    = 7'h5c;

	localparam int unsigned OPT_HEALTHY_MIN_BIT = 0;
	localparam int unsigned PASS_A_IDX_LSB      = 0;
	localparam int unsigned PASS_A_EN_BIT       = 3;
	localparam int unsigned PASS_B_IDX_LSB      = 4;
	localparam int unsigned PASS_B_EN_BIT       = 7;
	localparam int unsigned STAT_OUT_LSB        = 0;
	localparam int unsigned STAT_COND_LSB       = 8;
	localparam logic [OVL_W-1:0] OVL_TIME_RESET = 16'h0000;

	typedef struct packed {
		logic        alarm_active;
		logic        speed_over_level;
		logic        armature_over_level;
		logic        drive_running;
		logic        armature_at_limit;
		logic        current_overlimit;
		logic        field_weakening_active;
		logic        field_over_level;
		logic        reference_over_level;
		logic        warning_shown;
		logic        fieldbus_bit;
		logic [15:0] ramp_output;
		logic [15:0] ramp_setpoint;
	} cos_drive_type;

	typedef struct packed {
		logic [6:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} cos_avm_req_type;

endpackage

// >>> design/cos_top.sv
/*
 * cos_top: five configurable digital outputs with source selection,
 * turn-on and turn-off delays, inversion and an Avalon-MM register slave.
 * assumes drive condition inputs and configurable inputs are synchronous
 * to clock; software writes all settings over the register bus.
 */
`timescale 1ns/1ns

// What this block does
// - five source selectors accept codes 0 to 13; resets 0,1,2,5,4
// - code 0: condition true when no alarm is active
// - code 1: condition true while speed or voltage exceeds threshold
// - code 2: condition true while armature current exceeds threshold
// - code 3: ramp output reached ramp setpoint, only while drive runs
// - code 4: armature current sits at present maximum permitted value
// - code 5: drive is actively controlling the motor
// - code 6: current overlimit has lasted the whole configured overlimit time
// - code 7: dynamic field weakening regulation in progress
// - code 8: field current exceeds its threshold
// - code 9: reference exceeds its threshold
// - code 10: no warning is shown on the status page
// - code 11: output follows a fieldbus digital bit
// - code 12: pass-through input A with the output's delays and inversion
// - code 13: pass-through input B with the output's delays and inversion
// - per-output turn-on delay 0 to 600.0 s, default zero
// - output asserts only after condition held for full turn-on delay
// - at-speed compares only main ramp setpoint, no additional reference
// - per-output turn-off delay 0 to 600.0 s, measured from condition loss
// - healthy source with minimum option: turn-off delay at least 500 ms
module cos_top
	import cos_pkg::*;
#(
	parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire cos_avm_req_type       avm_req,
	output logic [31:0]                avm_readdata,
	output logic                       avm_waitrequest,
	input  wire cos_drive_type         drive,
	input  wire logic [NUM_IN-1:0]     configurable_input,
	output logic [NUM_OUT-1:0]         configurable_output
);

	generate
		if (MS_CYCLES_P < 2 || MS_CYCLES_P > 131072) begin : g_bad_param
			$error("cos_top: MS_CYCLES_P out of range");
		end
	endgenerate

	logic [SRC_W-1:0]  output_source_select   [NUM_OUT];
	logic [DLY_W-1:0]  output_turn_on_delay   [NUM_OUT];
	logic [DLY_W-1:0]  output_turn_off_delay  [NUM_OUT];
	logic [NUM_OUT-1:0] output_inversion_setting;
	logic              healthy_min_delay_option;
	logic [7:0]        pass_sel;
	logic [OVL_W-1:0]  overlimit_time_setting;
	logic [NUM_OUT-1:0] out_state;
	logic [NUM_OUT-1:0] cond_sel;
	logic [13:0]       cond_vec;
	logic [16:0]       ovl_cyc;
	logic [OVL_W-1:0]  ovl_ms;
	logic              pass_through_input_a;
	logic              pass_through_input_b;
	logic              full_overlimit;
	logic              bus_req;
	logic              bus_write;
	logic [2:0]        acc_out;
	logic [6:0]        acc_ofs;
	logic [31:0]       next_readdata;

	// bus access: request seen at one edge, waitrequest low the next cycle
	assign bus_req   = (avm_req.read || avm_req.write) && avm_waitrequest;
	assign bus_write = avm_req.write && !avm_waitrequest;
	assign acc_out   = avm_req.address[6:4];
	assign acc_ofs   = {3'h0, avm_req.address[3:0]};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			avm_waitrequest <= 1'b1;
		end else if (bus_req) begin
			avm_waitrequest <= 1'b0;
		end else begin
			avm_waitrequest <= 1'b1;
		end
	end

	always_comb begin
		next_readdata = 32'h0000_0000;
		if (acc_out < 3'(NUM_OUT)) begin
			unique case (acc_ofs)
				OFS_SRC: next_readdata = {28'h0, output_source_select[acc_out]};
				OFS_ON:  next_readdata = {12'h0, output_turn_on_delay[acc_out]};
				OFS_OFF: next_readdata = {12'h0, output_turn_off_delay[acc_out]};
				OFS_INV: next_readdata = {31'h0, output_inversion_setting[acc_out]};
				default: next_readdata = 32'h0000_0000;
			endcase
		end else begin
			unique case (avm_req.address)
				ADR_OPTION:   next_readdata = {31'h0, healthy_min_delay_option};
				ADR_PASS_SEL: next_readdata = {24'h0, pass_sel};
				ADR_OVL_TIME: next_readdata = {16'h0, overlimit_time_setting};
				ADR_STATUS:   next_readdata = {10'h0, cond_vec, 3'h0, configurable_output};
				default:      next_readdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			avm_readdata <= 32'h0000_0000;
		end else if (bus_req && avm_req.read) begin
			avm_readdata <= next_readdata;
		end
	end

	// out-of-range codes and delays are refused: the old value stays
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_OUT; i++) begin
				output_source_select[i]  <= SRC_RESET[i*SRC_W +: SRC_W];
				output_turn_on_delay[i]  <= DELAY_RESET;
				output_turn_off_delay[i] <= DELAY_RESET;
			end
			output_inversion_setting <= '0;
			healthy_min_delay_option <= 1'b0;
			pass_sel                 <= 8'h00;
			overlimit_time_setting   <= OVL_TIME_RESET;
		end else if (bus_write) begin
			if (acc_out < 3'(NUM_OUT)) begin
				unique case (acc_ofs)
					OFS_SRC: if (avm_req.writedata <= 32'(SRC_MAX)) begin
						output_source_select[acc_out] <= avm_req.writedata[SRC_W-1:0];
					end
					OFS_ON: if (avm_req.writedata <= 32'(DELAY_MAX_MS)) begin
						output_turn_on_delay[acc_out] <= avm_req.writedata[DLY_W-1:0];
					end
					OFS_OFF: if (avm_req.writedata <= 32'(DELAY_MAX_MS)) begin
						output_turn_off_delay[acc_out] <= avm_req.writedata[DLY_W-1:0];
					end
					OFS_INV: output_inversion_setting[acc_out] <= avm_req.writedata[0];
					default: ;
				endcase
			end else begin
				unique case (avm_req.address)
					ADR_OPTION:
						healthy_min_delay_option <= avm_req.writedata[OPT_HEALTHY_MIN_BIT];
					ADR_PASS_SEL: pass_sel <= avm_req.writedata[7:0];
					ADR_OVL_TIME: overlimit_time_setting <= avm_req.writedata[OVL_W-1:0];
					default: ;
				endcase
			end
		end
	end

	// overlimit duration timer, counted in whole milliseconds
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ovl_cyc <= 17'h0;
			ovl_ms  <= '0;
		end else if (!drive.current_overlimit) begin
			ovl_cyc <= 17'h0;
			ovl_ms  <= '0;
		end else if (ovl_cyc == 17'(MS_CYCLES_P - 1)) begin
			ovl_cyc <= 17'h0;
			if (ovl_ms != '1) begin
				ovl_ms <= ovl_ms + 1'b1;
			end
		end else begin
			ovl_cyc <= ovl_cyc + 1'b1;
		end
	end

	assign full_overlimit = drive.current_overlimit && (ovl_ms >= overlimit_time_setting);

	// pass-through A and B each pick one input by their own 3-bit index; disabled means low
	assign pass_through_input_a = pass_sel[PASS_A_EN_BIT] &&
		configurable_input[pass_sel[PASS_A_IDX_LSB +: 3]];
	assign pass_through_input_b = pass_sel[PASS_B_EN_BIT] &&
		configurable_input[pass_sel[PASS_B_IDX_LSB +: 3]];

	always_comb begin
		cond_vec                = '0;
		cond_vec[SRC_HEALTHY]   = !drive.alarm_active;
		cond_vec[SRC_SPEED]     = drive.speed_over_level;
		cond_vec[SRC_ARM_LEVEL] = drive.armature_over_level;
		// the extra speed reference never enters this compare
		cond_vec[SRC_AT_SPEED]  = drive.drive_running &&
			(drive.ramp_output == drive.ramp_setpoint);
		cond_vec[SRC_AT_LIMIT]  = drive.armature_at_limit;
		cond_vec[SRC_RUNNING]   = drive.drive_running;
		cond_vec[SRC_FULL_OVL]  = full_overlimit;
		cond_vec[SRC_FLD_WEAK]  = drive.field_weakening_active;
		cond_vec[SRC_FLD_LEVEL] = drive.field_over_level;
		cond_vec[SRC_REF_LEVEL] = drive.reference_over_level;
		cond_vec[SRC_NO_WARN]   = !drive.warning_shown;
		cond_vec[SRC_FIELDBUS]  = drive.fieldbus_bit;
		cond_vec[SRC_PASS_A]    = pass_through_input_a;
		cond_vec[SRC_PASS_B]    = pass_through_input_b;
	end

	genvar g;
	generate
		for (g = 0; g < NUM_OUT; g++) begin : g_out
			logic [16:0]      cyc_cnt;
			logic [DLY_W-1:0] ms_cnt;
			logic [DLY_W-1:0] eff_off;
			logic [DLY_W-1:0] target;

			assign cond_sel[g] = cond_vec[output_source_select[g]];
			assign eff_off = (healthy_min_delay_option &&
				output_source_select[g] == SRC_HEALTHY &&
				output_turn_off_delay[g] < HEALTHY_MIN_MS) ?
				HEALTHY_MIN_MS : output_turn_off_delay[g];
			assign target = cond_sel[g] ? output_turn_on_delay[g] : eff_off;

			// each output has its own prescaler so delays start at the change
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					out_state[g] <= 1'b0;
					cyc_cnt      <= 17'h0;
					ms_cnt       <= '0;
				end else if (cond_sel[g] == out_state[g]) begin
					cyc_cnt <= 17'h0;
					ms_cnt  <= '0;
				end else if (ms_cnt >= target) begin
					out_state[g] <= cond_sel[g];
					cyc_cnt      <= 17'h0;
					ms_cnt       <= '0;
				end else if (cyc_cnt == 17'(MS_CYCLES_P - 1)) begin
					cyc_cnt <= 17'h0;
					ms_cnt  <= ms_cnt + 1'b1;
				end else begin
					cyc_cnt <= cyc_cnt + 1'b1;
				end
			end

			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					configurable_output[g] <= 1'b0;
				end else begin
					configurable_output[g] <= out_state[g] ^ output_inversion_setting[g];
				end
			end

			AST_TURN_ON_HELD: assert property (@(posedge clock) disable iff (!rst_n)
				$rose(out_state[g]) |-> $past(cond_sel[g]) &&
				$past(ms_cnt) >= $past(output_turn_on_delay[g]))
				else $error("output asserted before turn-on delay elapsed");

			AST_TURN_OFF_HELD: assert property (@(posedge clock) disable iff (!rst_n)
				$fell(out_state[g]) |-> !$past(cond_sel[g]) &&
				$past(ms_cnt) >= $past(output_turn_off_delay[g]))
				else $error("output released before turn-off delay elapsed");

			AST_HEALTHY_MIN: assert property (@(posedge clock) disable iff (!rst_n)
				$fell(out_state[g]) && $past(healthy_min_delay_option) &&
				$past(output_source_select[g]) == SRC_HEALTHY |->
				$past(ms_cnt) >= HEALTHY_MIN_MS)
				else $error("healthy indication dropped inside minimum delay");

			AST_RESTART: assert property (@(posedge clock) disable iff (!rst_n)
				!out_state[g] && !cond_sel[g] |=> ms_cnt == '0 && cyc_cnt == 17'h0 &&
				!out_state[g])
				else $error("turn-on timer not restarted after condition loss");

			AST_PIN_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
				output_source_select[g] == SRC_PASS_A && pass_sel[PASS_A_EN_BIT] |->
				cond_sel[g] == configurable_input[pass_sel[2:0]] ##1
				configurable_output[g] == ($past(out_state[g]) ^
				$past(output_inversion_setting[g])))
				else $error("pass-through output does not follow its input");
		end
	endgenerate

	AST_SRC_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
		bus_write && acc_out == 3'h0 && acc_ofs == OFS_SRC &&
		avm_req.writedata > 32'(SRC_MAX) |=> $stable(output_source_select[0]))
		else $error("illegal source code accepted");

	AST_AT_SPEED_RUN: assert property (@(posedge clock) disable iff (!rst_n)
		!drive.drive_running |-> !cond_vec[SRC_AT_SPEED])
		else $error("at-speed reported while drive stopped");

	AST_FULL_OVL: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(full_overlimit) && overlimit_time_setting != '0 |->
		$past(drive.current_overlimit, 1))
		else $error("full overlimit without sustained overlimit");

endmodule

// >>> bench/cos_relay_model.sv
/*
 * cos_relay_model: external relay coils wired to the configurable outputs.
 * assumes one coil per output pin, energised while the pin is high.
 */
`timescale 1ns/1ns
module cos_relay_model
	import cos_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               rst_n,
	input  wire logic [NUM_OUT-1:0] coil,
	output logic [NUM_OUT-1:0]      contact_closed
);
	// contacts pick up one cycle after the coil; bounce is not modelled
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			contact_closed <= '0;
		end else begin
			contact_closed <= coil;
		end
	end
endmodule

// >>> bench/cos_top_tb.sv
/*
 * cos_top_tb: register-driven tests of source selection and output timing.
 * assumes MS_CYCLES_P of 10, so one millisecond of delay is ten cycles.
 */
`timescale 1ns/1ns
module cos_top_tb
	import cos_pkg::*;
;
	localparam int unsigned MSC = 10;
	logic                  clock;
	logic                  rst_n;
	cos_avm_req_type       avm_req;
	logic [31:0]           avm_readdata;
	logic                  avm_waitrequest;
	cos_drive_type         drive;
	logic [NUM_IN-1:0]     configurable_input;
	logic [NUM_OUT-1:0]    configurable_output;
	logic [NUM_OUT-1:0]    contact_closed;
	int                    errors;
	int                    samples_checked;
	logic [31:0]           rd;

	cos_top #(.MS_CYCLES_P(MSC)) dut_u (
		.clock               (clock),
		.rst_n               (rst_n),
		.avm_req             (avm_req),
		.avm_readdata        (avm_readdata),
		.avm_waitrequest     (avm_waitrequest),
		.drive               (drive),
		.configurable_input  (configurable_input),
		.configurable_output (configurable_output)
	);

	cos_relay_model relay_u (
		.clock          (clock),
		.rst_n          (rst_n),
		.coil           (configurable_output),
		.contact_closed (contact_closed)
	);

	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	task automatic finish_test();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t %s: expected %h got %h", $time, what, exp, got);
		end
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clock);
	endtask

	// holds the request until waitrequest is sampled low, then idles a cycle
	task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		avm_req <= '{address: a, read: !wr, write: wr, writedata: d};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avm_waitrequest !== 1'b0 && n < 100);
		q = avm_readdata;
		avm_req <= '0;
		if (n >= 100) begin
			errors++;
			$display("ERROR %0t bus access never answered", $time);
		end
		@(posedge clock);
	endtask

	// drives the condition behind source code c to val, all others idle-false except running (code 5) for code 3
	task automatic apply(input int c, input logic val);
		cos_drive_type d;
		logic [NUM_IN-1:0] ci;
		d = '0;
		ci = '0;
		d.alarm_active = 1'b1;
		d.warning_shown = 1'b1;
		d.ramp_setpoint = 16'h0100;
		d.ramp_output = 16'h00ff;
		case (c)
			0: d.alarm_active = !val;
			1: d.speed_over_level = val;
			2: d.armature_over_level = val;
			3: begin
				d.drive_running = 1'b1;
				d.ramp_output = val ? 16'h0100 : 16'h00ff;
			end
			4: d.armature_at_limit = val;
			5: d.drive_running = val;
			6: d.current_overlimit = val;
			7: d.field_weakening_active = val;
			8: d.field_over_level = val;
			9: d.reference_over_level = val;
			10: d.warning_shown = !val;
			11: d.fieldbus_bit = val;
			12: ci[2] = val;
			default: ci[5] = val;
		endcase
		drive <= d;
		configurable_input <= ci;
	endtask

	initial begin
		waitc(40000);
		errors++;
		$display("ERROR %0t watchdog expired", $time);
		finish_test();
	end

	initial begin
		rst_n = 1'b0;
		avm_req = '0;
		drive = '0;
		configurable_input = '0;
		errors = 0;
		samples_checked = 0;
		waitc(16);
		rst_n <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < NUM_OUT; i++) begin
			bus(1'b0, OFS_OUT_BLOCK * i + OFS_SRC, '0, rd);
			chk({28'h0000000, SRC_RESET[i*SRC_W +: SRC_W]}, rd, "source reset");
			bus(1'b0, OFS_OUT_BLOCK * i + OFS_ON, '0, rd);
			chk(32'h00000000, rd, "on delay reset");
		end
		bus(1'b1, OFS_SRC, 32'h0000000e, rd);
		bus(1'b0, OFS_SRC, '0, rd);
		chk(32'h00000000, rd, "code above 13 kept out");
		bus(1'b0, 7'h60, '0, rd);
		chk(32'h00000000, rd, "unmapped read");
		bus(1'b1, ADR_PASS_SEL, 32'h000000da, rd);
		for (int c = 0; c <= 13; c++) begin
			bus(1'b1, OFS_SRC, c, rd);
			apply(c, 1'b1);
			waitc(4);
			chk(32'h1, {31'h0, configurable_output[0]}, "condition true");
			apply(c, 1'b0);
			waitc(4);
			chk(32'h0, {31'h0, configurable_output[0]}, "condition false");
		end
		bus(1'b1, OFS_INV, 32'h1, rd);
		waitc(4);
		chk(32'h1, {31'h0, configurable_output[0]}, "inverted pass-through");
		bus(1'b1, OFS_INV, 32'h0, rd);
		bus(1'b1, OFS_SRC, SRC_AT_SPEED, rd);
		apply(3, 1'b1);
		drive.drive_running <= 1'b0;
		waitc(4);
		chk(32'h0, {31'h0, configurable_output[0]}, "at speed needs running");
		bus(1'b1, OFS_SRC, SRC_RUNNING, rd);
		bus(1'b1, OFS_ON, 32'h2, rd);
		apply(5, 1'b1);
		waitc(15);
		apply(5, 1'b0);
		waitc(2);
		apply(5, 1'b1);
		waitc(15);
		chk(32'h0, {31'h0, configurable_output[0]}, "timer restarted");
		waitc(9);
		chk(32'h1, {31'h0, configurable_output[0]}, "on after delay");
		bus(1'b1, OFS_OFF, 32'h3, rd);
		apply(5, 1'b0);
		waitc(28);
		chk(32'h1, {31'h0, configurable_output[0]}, "held by off delay");
		waitc(7);
		chk(32'h0, {31'h0, configurable_output[0]}, "off after delay");
		bus(1'b1, OFS_ON, 32'h0, rd);
		bus(1'b1, OFS_OFF, 32'h0, rd);
		bus(1'b1, ADR_OVL_TIME, 32'h3, rd);
		bus(1'b1, OFS_SRC, SRC_FULL_OVL, rd);
		apply(6, 1'b1);
		waitc(20);
		chk(32'h0, {31'h0, configurable_output[0]}, "overlimit too short");
		waitc(30);
		chk(32'h1, {31'h0, configurable_output[0]}, "full overlimit");
		bus(1'b1, ADR_OPTION, 32'h1, rd);
		bus(1'b1, OFS_SRC, SRC_HEALTHY, rd);
		apply(0, 1'b1);
		waitc(4);
		apply(0, 1'b0);
		waitc(4990);
		chk(32'h1, {31'h0, configurable_output[0]}, "healthy minimum hold");
		waitc(20);
		chk(32'h0, {31'h0, configurable_output[0]}, "healthy released");
		finish_test();
	end
endmodule
